// >>> design/artd_transfer.sv
`timescale 1ns/1ns
module artd_transfer (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // Instruction from the core
    input  wire logic                        instr_valid,
    input  wire logic [9:0]                  instr,
    input  wire artd_pkg::artd_operand_type  operand,
    input  wire logic                        carry_in,
    // Target registers
    output logic [3:0]                       adc_ctrl_three,
    output logic [7:0]                       first_timer_reload,
    output logic [7:0]                       third_timer_reload,
    output logic                             clock_ctrl_reg,
    // Core feedback
    output logic                             done,
    output logic                             carry_out,
    output logic                             skip
);
    artd_pkg::artd_decode_type dec;
    logic [3:0] adc_q, adc_d;
    logic [7:0] r1_q, r1_d, r3_q, r3_d;
    logic       clk_q, clk_d;
    logic       done_q, done_d;
    logic       cy_q, cy_d;
    logic       skip_q, skip_d;
    logic       exec;

    artd_decoder u_dec (
        .instr (instr),
        .dec   (dec)
    );

    assign exec = instr_valid && dec.hit;

    always_comb begin
        adc_d  = adc_q;
        r1_d   = r1_q;
        r3_d   = r3_q;
        clk_d  = clk_q;
        done_d = exec;                 // Single-cycle completion
        cy_d   = carry_in;             // Carry passes through untouched
        skip_d = 1'b0;                 // No transfer ever requests a skip
        if (instr_valid) begin
            unique case (dec.op)
                artd_pkg::ARTD_OP_ADC: adc_d = operand.acc;
                artd_pkg::ARTD_OP_TMR1: begin
                    r1_d[artd_pkg::RLD_HI_LSB +: artd_pkg::NIB_W] = operand.aux;
                    r1_d[artd_pkg::RLD_LO_LSB +: artd_pkg::NIB_W] = operand.acc;
                end
                artd_pkg::ARTD_OP_TMR3: begin
                    r3_d[artd_pkg::RLD_HI_LSB +: artd_pkg::NIB_W] = operand.aux;
                    r3_d[artd_pkg::RLD_LO_LSB +: artd_pkg::NIB_W] = operand.acc;
                end
                artd_pkg::ARTD_OP_CLOCK: clk_d = operand.acc[0];
                artd_pkg::ARTD_OP_NONE: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            adc_q  <= artd_pkg::ADC_THREE_RST;
            r1_q   <= artd_pkg::RELOAD_RST;
            r3_q   <= artd_pkg::RELOAD_RST;
            clk_q  <= artd_pkg::CLOCK_CTRL_RST;
            done_q <= 1'b0;
            cy_q   <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            adc_q  <= adc_d;
            r1_q   <= r1_d;
            r3_q   <= r3_d;
            clk_q  <= clk_d;
            done_q <= done_d;
            cy_q   <= cy_d;
            skip_q <= skip_d;
        end
    end

    assign adc_ctrl_three     = adc_q;
    assign first_timer_reload = r1_q;
    assign third_timer_reload = r3_q;
    assign clock_ctrl_reg     = clk_q;
    assign done               = done_q;
    assign carry_out          = cy_q;
    // Registered so the skip line behaves like every other core feedback output
    assign skip               = skip_q;

    a_adc_copy: assert property (@(posedge clk) disable iff (reset)
        instr_valid && instr == artd_pkg::OPC_ADC_THREE |=> adc_ctrl_three == $past(operand.acc))
        else $error("adc control three not loaded from accumulator");
    a_r1_high: assert property (@(posedge clk) disable iff (reset)
        instr_valid && instr == artd_pkg::OPC_TMR1_RLD |=> first_timer_reload[7:4] == $past(operand.aux))
        else $error("timer 1 reload high nibble wrong");
    a_r1_low: assert property (@(posedge clk) disable iff (reset)
        instr_valid && instr == artd_pkg::OPC_TMR1_RLD |=> first_timer_reload[3:0] == $past(operand.acc))
        else $error("timer 1 reload low nibble wrong");
    a_r3_high: assert property (@(posedge clk) disable iff (reset)
        instr_valid && instr == artd_pkg::OPC_TMR3_RLD |=> third_timer_reload[7:4] == $past(operand.aux))
        else $error("timer 3 reload high nibble wrong");
    a_r3_low: assert property (@(posedge clk) disable iff (reset)
        instr_valid && instr == artd_pkg::OPC_TMR3_RLD |=> third_timer_reload[3:0] == $past(operand.acc))
        else $error("timer 3 reload low nibble wrong");
    a_clock_bit: assert property (@(posedge clk) disable iff (reset)
        instr_valid && instr == artd_pkg::OPC_CLOCK_CTRL |=> clock_ctrl_reg == $past(operand.acc[0]))
        else $error("clock control bit not loaded");
    a_one_cycle: assert property (@(posedge clk) disable iff (reset)
        instr_valid && dec.hit |=> done && carry_out == $past(carry_in) && !skip)
        else $error("transfer not single cycle or carry changed");
    a_r1_hold: assert property (@(posedge clk) disable iff (reset)
        !(instr_valid && instr == artd_pkg::OPC_TMR1_RLD) |=> $stable(first_timer_reload))
        else $error("timer 1 reload changed without its opcode");
    a_r3_hold: assert property (@(posedge clk) disable iff (reset)
        !(instr_valid && instr == artd_pkg::OPC_TMR3_RLD) |=> $stable(third_timer_reload))
        else $error("timer 3 reload changed without its opcode");
    a_adc_hold: assert property (@(posedge clk) disable iff (reset)
        !(instr_valid && instr == artd_pkg::OPC_ADC_THREE) |=> $stable(adc_ctrl_three))
        else $error("adc control three changed without its opcode");
    a_clock_hold: assert property (@(posedge clk) disable iff (reset)
        !(instr_valid && instr == artd_pkg::OPC_CLOCK_CTRL) |=> $stable(clock_ctrl_reg))
        else $error("clock control bit changed without its opcode");
    a_done_refuse: assert property (@(posedge clk) disable iff (reset)
        !(instr_valid && dec.hit) |=> !done)
        else $error("done raised without a recognised transfer");
    a_carry_pass: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> carry_out == $past(carry_in))
        else $error("carry flag altered");
    a_skip_low: assert property (@(posedge clk) disable iff (reset)
        !skip)
        else $error("skip requested by a transfer");
    a_reset_clear: assert property (@(posedge clk)
        reset |=> !done && !skip && first_timer_reload == artd_pkg::RELOAD_RST)
        else $error("reset did not clear the outputs");
endmodule : artd_transfer

// >>> shared/artd_pkg.sv
package artd_pkg;
    localparam int OPC_W = 10;
    localparam int NIB_W = 4;
    localparam int RLD_W = 8;
    // Instruction codes of the four transfers
    localparam logic [9:0] OPC_ADC_THREE  = 10'h206;
    localparam logic [9:0] OPC_TMR1_RLD   = 10'h23F;
    localparam logic [9:0] OPC_TMR3_RLD   = 10'h23B;
    localparam logic [9:0] OPC_CLOCK_CTRL = 10'h209;
    // Reset values of the target registers
    localparam logic [3:0] ADC_THREE_RST  = 4'h0;
    localparam logic [7:0] RELOAD_RST     = 8'h00;
    localparam logic [0:0] CLOCK_CTRL_RST = 1'h0;
    // Field positions within the reload registers
    localparam int RLD_HI_LSB = 4;
    localparam int RLD_LO_LSB = 0;

    typedef enum logic [2:0] {
        ARTD_OP_NONE   = 3'h0,
        ARTD_OP_ADC    = 3'h1,
        ARTD_OP_TMR1   = 3'h3,
        ARTD_OP_TMR3   = 3'h2,
        ARTD_OP_CLOCK  = 3'h6
    } artd_op_type;

    // Operand pair travelling from the core
    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] aux;
    } artd_operand_type;

    // Decode result
    typedef struct packed {
        artd_op_type op;
        logic        hit;
    } artd_decode_type;
endpackage : artd_pkg

// >>> design/artd_decoder.sv
`timescale 1ns/1ns
module artd_decoder (
    // Instruction word
    input  wire logic [9:0]             instr,
    // Decode result
    output artd_pkg::artd_decode_type   dec
);
    always_comb begin
        dec.hit = 1'b1;
        unique case (instr)
            artd_pkg::OPC_ADC_THREE:  dec.op = artd_pkg::ARTD_OP_ADC;
            artd_pkg::OPC_TMR1_RLD:   dec.op = artd_pkg::ARTD_OP_TMR1;
            artd_pkg::OPC_TMR3_RLD:   dec.op = artd_pkg::ARTD_OP_TMR3;
            artd_pkg::OPC_CLOCK_CTRL: dec.op = artd_pkg::ARTD_OP_CLOCK;
            default: begin
                dec.op  = artd_pkg::ARTD_OP_NONE;
                dec.hit = 1'b0;
            end
        endcase
    end
endmodule : artd_decoder

// >>> verification/artd_tb_top.sv
`timescale 1ns/1ns
module accumulator_register_transfer_decode_tb_top;
    logic                       clk;
    logic                       reset;
    logic                       instr_valid;
    logic [9:0]                 instr;
    artd_pkg::artd_operand_type operand;
    logic                       carry_in;
    logic [3:0]                 adc_ctrl_three;
    logic [7:0]                 first_timer_reload;
    logic [7:0]                 third_timer_reload;
    logic                       clock_ctrl_reg;
    logic                       done;
    logic                       carry_out;
    logic                       skip;
    logic [7:0]                 st;
    int                         num_errors = 0;
    int                         n_checks = 0;

    assign st = {adc_ctrl_three, clock_ctrl_reg, done, carry_out, skip};

    artd_transfer u_artd_transfer (
        .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
        .operand(operand), .carry_in(carry_in), .adc_ctrl_three(adc_ctrl_three),
        .first_timer_reload(first_timer_reload), .third_timer_reload(third_timer_reload),
        .clock_ctrl_reg(clock_ctrl_reg), .done(done), .carry_out(carry_out), .skip(skip)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Entered at a rising edge; returns at the edge that samples the request
    task exec(input logic v, input logic [9:0] op, input logic [3:0] a,
              input logic [3:0] b, input logic c);
        instr_valid <= v;
        instr       <= op;
        operand     <= '{acc: a, aux: b};
        carry_in    <= c;
        @(posedge clk);
    endtask : exec

    task fin;
        instr_valid <= 1'b0;
        #1;
    endtask : fin

    // Done must drop one cycle after the last transfer
    task tail;
        @(posedge clk);
        #1;
        chk(done, 8'h00, "done"); // Single-cycle pulse
        @(posedge clk);
    endtask : tail

    task do_reset;
        reset       <= 1'b1;
        instr_valid <= 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(st, 8'h00, "rst st"); // No done, carry or skip out of reset
        chk(first_timer_reload | third_timer_reload, 8'h00, "rst rld");
        @(posedge clk);
    endtask : do_reset

    task t_adc;
        exec(1'b1, artd_pkg::OPC_ADC_THREE, 4'h9, 4'h6, 1'b1);
        fin;
        chk(st, 8'h96, "adc"); // Whole nibble, carry kept, no skip
        chk(first_timer_reload, 8'h00, "adc side"); // No stray write
        tail;
    endtask : t_adc

    task t_reloads;
        exec(1'b1, artd_pkg::OPC_TMR1_RLD, 4'h5, 4'hA, 1'b0);
        exec(1'b1, artd_pkg::OPC_TMR3_RLD, 4'h3, 4'hC, 1'b0);
        fin;
        chk(first_timer_reload, 8'hA5, "rld1"); // Aux high, acc low
        chk(third_timer_reload, 8'hC3, "rld3"); // Aux high, acc low
        chk(st, 8'h94, "rld st"); // Back to back still one cycle
        tail;
    endtask : t_reloads

    task t_clock;
        exec(1'b1, artd_pkg::OPC_CLOCK_CTRL, 4'h7, 4'h0, 1'b1);
        fin;
        chk(st, 8'h9E, "clk set"); // Bit 0 of acc only
        tail;
        exec(1'b1, artd_pkg::OPC_CLOCK_CTRL, 4'hE, 4'hF, 1'b0);
        fin;
        chk(st, 8'h94, "clk clr"); // Upper acc bits ignored
        tail;
    endtask : t_clock

    // Single-bit neighbours of a valid code; bit 2 gives the other reload code
    task t_refuse;
        for (int i = 0; i < 10; i++) begin
            if (i != 2) begin
                exec(1'b1, artd_pkg::OPC_TMR1_RLD ^ (10'h001 << i), 4'hF, 4'hF, 1'b1);
                #1;
                chk(st, 8'h92, "near op"); // Only exact codes decode
                @(posedge clk);
            end
        end
        exec(1'b0, artd_pkg::OPC_TMR1_RLD, 4'hF, 4'hF, 1'b0);
        fin;
        chk(first_timer_reload, 8'hA5, "ref rld1"); // Unchanged
        chk(third_timer_reload, 8'hC3, "ref rld3"); // Unchanged
        tail;
    endtask : t_refuse

    task stop_test;
        $display("errors=%0d checks=%0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    initial begin
        #5000;
        num_errors++;
        stop_test;
    end

    initial begin
        reset       = 1'b1;
        instr_valid = 1'b0;
        instr       = 10'h000;
        operand     = '0;
        carry_in    = 1'b0;
        do_reset;
        t_adc;
        t_reloads;
        t_clock;
        t_refuse;
        do_reset;
        stop_test;
    end
endmodule : accumulator_register_transfer_decode_tb_top
